//--- rtl/dram_bank_dev.sv
// Purpose: device end: mode bits, per-bank state, burst select
// Assumes: controller keeps its own ordering duties
// Notes: burst_beats_q 0 = none, 1 = chop four, 2 = eight
//
// Functional notes
// RULE1: auto self-refresh needs auto=1, range=0
// RULE2: auto mode lets device manage self-refresh
// RULE3: controller keeps auto bit 0 if unsupported; here the controller forwards it and the device masks it with ASR_SUPPORT
// RULE4: without auto, controller sets range bit
// RULE5: range 0 selects normal refresh rate
// RULE6: range 1 selects extended refresh rate
// RULE7: range bit only with extended support
// RULE8: auto and range both set is illegal
// RULE9: active takes bank and row inputs
// RULE10: row stays open until precharged
// RULE11: precharge before opening another row
// RULE12: precharge closes one bank or all
// RULE13: no activation before precharge time
// RULE14: other-bank access allowed during auto precharge
// RULE15: idle bank needs activation before access
// RULE16: repeat precharge restarts precharge timer
// RULE17: select bit 0 chop four, 1 eight
// RULE18: select bit is burst control only
// RULE19: eight beats when field eight or on-fly
// RULE20: state tracked separately per bank
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "dram_cmd_defs.svh"
module dram_bank_dev #(
    parameter bit EXT_TEMP_SUPPORT = 1'b1,
    parameter bit ASR_SUPPORT = 1'b1
) (
    input wire logic core_clk,
    input wire logic nrst,
    dram_cmd_if.dev link,
    output logic [1:0] sr_rate_q,
    output logic [14:0] open_row_q,
    output logic [7:0] bank_open_q
);
    localparam logic [3:0] PRE_CYC = 4'(`PRECHARGE_CYC);
    localparam logic [2:0] CCD_CHOP = 3'(`CCD_CHOP);

    // ========================================
    // mode registers
    logic [14:0] mr0_q, mr0_d, mr2_q, mr2_d;
    logic [1:0] rate_d;
    logic asr_bit, srt_bit;
    always_comb begin
        mr0_d = mr0_q;
        mr2_d = mr2_q;
        if (link.cmd == dram_cmd_pkg::CMD_MRS) begin
            if (link.mr_sel == 2'h0) begin
                mr0_d = link.row_address_inputs;
            end else if (link.mr_sel == 2'h2) begin
                mr2_d = link.row_address_inputs;
            end
        end
        asr_bit = mr2_q[`MR2_ASR_BIT] & ASR_SUPPORT;
        srt_bit = mr2_q[`MR2_SRT_BIT];
        rate_d = `SR_RATE_NORMAL; // RULE5
        if (asr_bit && !srt_bit) begin
            rate_d = `SR_RATE_AUTO; // RULE1 RULE2
        end else if (!asr_bit && srt_bit && EXT_TEMP_SUPPORT) begin
            rate_d = `SR_RATE_EXTENDED; // RULE6 RULE7
        end
    end

    // ========================================
    // per-bank state
    dram_cmd_pkg::bank_state_e st_q [`NUM_BANKS];
    dram_cmd_pkg::bank_state_e st_d [`NUM_BANKS];
    logic [3:0] tmr_q [`NUM_BANKS];
    logic [3:0] tmr_d [`NUM_BANKS];
    logic [14:0] row_q [`NUM_BANKS];
    logic [14:0] row_d [`NUM_BANKS];
    logic [7:0] hit;
    logic err_d;
    logic [2:0] ccd_q, ccd_d;
    logic [1:0] beats_d;
    logic is_rw;

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_BANKS; gi++) begin : g_bank
            assign hit[gi] = (link.bank_select_inputs == 3'(gi)); // RULE9
            always_comb begin
                st_d[gi] = st_q[gi];
                tmr_d[gi] = tmr_q[gi];
                row_d[gi] = row_q[gi];
                if (st_q[gi] == dram_cmd_pkg::BANK_PRECHARGING) begin
                    if (tmr_q[gi] <= 4'h1) begin
                        st_d[gi] = dram_cmd_pkg::BANK_IDLE; // RULE13
                        tmr_d[gi] = 4'h0;
                    end else begin
                        tmr_d[gi] = tmr_q[gi] - 4'h1;
                    end
                end
                if (link.cmd == dram_cmd_pkg::CMD_ACTIVE && hit[gi] &&
                    st_q[gi] == dram_cmd_pkg::BANK_IDLE) begin
                    st_d[gi] = dram_cmd_pkg::BANK_OPEN; // RULE9 RULE10
                    row_d[gi] = link.row_address_inputs;
                end
                if (link.cmd == dram_cmd_pkg::CMD_PRECHARGE &&
                    (hit[gi] || link.all_banks)) begin
                    // idle or precharging bank accepted, timer restarts
                    st_d[gi] = dram_cmd_pkg::BANK_PRECHARGING; // RULE12 RULE16
                    tmr_d[gi] = PRE_CYC;
                end
            end
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    st_q[gi] <= dram_cmd_pkg::BANK_IDLE;
                    tmr_q[gi] <= 4'h0;
                    row_q[gi] <= 15'h0000;
                end else begin
                    st_q[gi] <= st_d[gi]; // RULE20
                    tmr_q[gi] <= tmr_d[gi];
                    row_q[gi] <= row_d[gi];
                end
            end
        end
    endgenerate

    // ========================================
    // command checks and burst length
    logic [7:0] open_d;
    always_comb begin
        is_rw = (link.cmd == dram_cmd_pkg::CMD_READ) ||
                (link.cmd == dram_cmd_pkg::CMD_WRITE);
        err_d = 1'b0;
        beats_d = 2'h0;
        ccd_d = (ccd_q != 3'h0) ? ccd_q - 3'h1 : 3'h0;
        for (int i = 0; i < `NUM_BANKS; i++) begin
            open_d[i] = (st_d[i] == dram_cmd_pkg::BANK_OPEN);
        end
        if (link.cmd == dram_cmd_pkg::CMD_ACTIVE &&
            st_q[link.bank_select_inputs] != dram_cmd_pkg::BANK_IDLE) begin
            err_d = 1'b1; // RULE11 RULE13
        end
        if (is_rw) begin
            // only the addressed bank matters; others may precharge
            if (st_q[link.bank_select_inputs] != dram_cmd_pkg::BANK_OPEN ||
                ccd_q != 3'h0) begin
                err_d = 1'b1; // RULE14 RULE15
            end else begin
                // select bit never reaches the column path
                unique case (mr0_q[1:0])
                    `BL_FIXED_EIGHT: beats_d = 2'h2; // RULE19
                    `BL_ON_FLY: beats_d = link.row_address_inputs[
                        `BURST_SEL_BIT] ? 2'h2 : 2'h1; // RULE17 RULE18
                    `BL_FIXED_CHOP: beats_d = 2'h1;
                    default: beats_d = 2'h2;
                endcase
                ccd_d = CCD_CHOP; // RULE17
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mr0_q <= 15'h0000;
            mr2_q <= 15'h0000;
            sr_rate_q <= `SR_RATE_NORMAL;
            link.cmd_err <= 1'b0;
            link.burst_beats_q <= 2'h0;
            link.burst_busy <= 1'b0;
            ccd_q <= 3'h0;
            open_row_q <= 15'h0000;
            bank_open_q <= 8'h00;
        end else begin
            mr0_q <= mr0_d;
            mr2_q <= mr2_d;
            sr_rate_q <= rate_d;
            link.cmd_err <= err_d;
            link.burst_beats_q <= beats_d;
            link.burst_busy <= (ccd_d != 3'h0);
            ccd_q <= ccd_d;
            open_row_q <= row_d[link.bank_select_inputs];
            bank_open_q <= open_d;
        end
    end
endmodule

//--- pkg/dram_cmd_defs.svh
// Purpose: constants for the bank command link
// Assumes: 10 MHz core clock
// Notes: timing counts derived from printed times
`ifndef DRAM_CMD_DEFS_SVH
`define DRAM_CMD_DEFS_SVH
`define CLK_PERIOD_NS 100
`define PRECHARGE_TIME_PS 13750
`define PRECHARGE_CYC \
    (((`PRECHARGE_TIME_PS) + (`CLK_PERIOD_NS * 1000) - 1) / \
     (`CLK_PERIOD_NS * 1000))
`define NUM_BANKS 8
`define BANK_W 3
`define ROW_W 15
`define COL_W 10
`define CCD_CHOP 4
`define CCD_EIGHT 4
`define MR2_ASR_BIT 6
`define MR2_SRT_BIT 7
`define MR0_BL_LSB 0
`define BL_FIXED_EIGHT 2'h0
`define BL_ON_FLY 2'h1
`define BL_FIXED_CHOP 2'h2
`define BURST_SEL_BIT 12
`define AUTO_PRE_BIT 10
`define SR_RATE_NORMAL 2'h0
`define SR_RATE_EXTENDED 2'h1
`define SR_RATE_AUTO 2'h2
`endif

//--- pkg/dram_cmd_pkg.sv
// Purpose: shared types for the bank command link
// Assumes: nothing
// Notes: command codes are abstract, not pin encodings
package dram_cmd_pkg;
    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_ACTIVE,
        CMD_PRECHARGE,
        CMD_READ,
        CMD_WRITE,
        CMD_MRS
    } cmd_e;
    typedef enum logic [1:0] {
        BANK_IDLE,
        BANK_OPEN,
        BANK_PRECHARGING
    } bank_state_e;
endpackage

//--- pkg/dram_cmd_if.sv
// Purpose: command link between controller and device
// Assumes: single clock, commands one cycle long
// Notes: modports ctrl and dev
`timescale 1ns/1ps
interface dram_cmd_if;
    dram_cmd_pkg::cmd_e cmd;
    logic [2:0] bank_select_inputs;
    logic [14:0] row_address_inputs;
    logic all_banks;
    logic [1:0] mr_sel;
    logic cmd_err;
    logic [1:0] burst_beats_q;
    logic burst_busy;
    modport ctrl (
        output cmd,
        output bank_select_inputs,
        output row_address_inputs,
        output all_banks,
        output mr_sel,
        input cmd_err,
        input burst_beats_q,
        input burst_busy
    );
    modport dev (
        input cmd,
        input bank_select_inputs,
        input row_address_inputs,
        input all_banks,
        input mr_sel,
        output cmd_err,
        output burst_beats_q,
        output burst_busy
    );
endinterface

//--- rtl/dram_bank_ctrl.sv
// Purpose: controller end: turns register orders into link commands
// Assumes: software writes one order at a time
// Notes: regs 0 cmd, 1 addr, 2 status, 3 reads zero
`timescale 1ns/1ps
`include "dram_cmd_defs.svh"
module dram_bank_ctrl (
    input wire logic core_clk,
    input wire logic nrst,
    dram_cmd_if.ctrl link,
    input wire logic [1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata_q
);
    // ========================================
    // orders; mode writes with both self-refresh bits set are dropped
    logic [31:0] addr_q, addr_d, rdata_d;
    logic err_seen_q, err_seen_d, order_ok;
    dram_cmd_pkg::cmd_e cmd_d;
    always_comb begin
        addr_d = addr_q;
        cmd_d = dram_cmd_pkg::CMD_NOP;
        err_seen_d = err_seen_q | link.cmd_err;
        rdata_d = 32'h0000_0000;
        order_ok = 1'b1;
        if (wr && addr == 2'h1) begin
            addr_d = wdata;
        end
        if (wr && addr == 2'h0) begin
            if (wdata[2:0] == 3'(dram_cmd_pkg::CMD_MRS) &&
                addr_q[17:16] == 2'h2 && addr_q[`MR2_ASR_BIT] &&
                addr_q[`MR2_SRT_BIT]) begin
                order_ok = 1'b0; // RULE8 RULE3 RULE4
            end
            if (link.burst_busy && (wdata[2:0] ==
                3'(dram_cmd_pkg::CMD_READ) ||
                wdata[2:0] == 3'(dram_cmd_pkg::CMD_WRITE))) begin
                order_ok = 1'b0; // RULE17
            end
            if (order_ok) begin
                cmd_d = dram_cmd_pkg::cmd_e'(wdata[2:0]);
            end
        end
        if (wr && addr == 2'h2) begin
            err_seen_d = link.cmd_err; // new error wins over clear
        end
        if (rd) begin
            unique case (addr)
                2'h0: rdata_d = {29'h0, 3'(cmd_d)};
                2'h1: rdata_d = addr_q;
                2'h2: rdata_d = {28'h0, link.burst_busy,
                    link.burst_beats_q, err_seen_q};
                2'h3: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            addr_q <= 32'h0000_0000;
            err_seen_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            link.cmd <= dram_cmd_pkg::CMD_NOP;
            link.bank_select_inputs <= 3'h0;
            link.row_address_inputs <= 15'h0000;
            link.all_banks <= 1'b0;
            link.mr_sel <= 2'h0;
        end else begin
            addr_q <= addr_d;
            err_seen_q <= err_seen_d;
            rdata_q <= rdata_d;
            link.cmd <= cmd_d; // RULE11 RULE15
            link.row_address_inputs <= addr_q[14:0];
            link.bank_select_inputs <= addr_q[20:18];
            link.mr_sel <= addr_q[17:16];
            link.all_banks <= addr_q[`AUTO_PRE_BIT];
        end
    end
endmodule

//--- bench/dram_bank_link_sva.sv
// Purpose: link checker for the controller and device pair
// Assumes: one clock, commands one cycle long
// Notes: keeps its own view of open banks and burst field
`timescale 1ns/1ps
module dram_bank_link_sva (
    input wire logic core_clk,
    input wire logic nrst,
    input wire dram_cmd_pkg::cmd_e cmd,
    input wire logic [2:0] bank_select_inputs,
    input wire logic [14:0] row_address_inputs,
    input wire logic all_banks,
    input wire logic [1:0] mr_sel,
    input wire logic cmd_err,
    input wire logic [1:0] burst_beats_q,
    input wire logic burst_busy
);
    // ==========================================
    // helper state
    logic [7:0] open_q;
    logic [7:0] open_d;
    logic [1:0] bl_q;
    logic [1:0] bl_d;
    logic rdwr;
    assign rdwr = cmd == dram_cmd_pkg::CMD_READ ||
                  cmd == dram_cmd_pkg::CMD_WRITE;
    // set on any activation: a closed view here is never open in the device
    always_comb begin
        open_d = open_q;
        bl_d = bl_q;
        if (cmd == dram_cmd_pkg::CMD_ACTIVE) begin
            open_d[bank_select_inputs] = 1'b1;
        end
        if (cmd == dram_cmd_pkg::CMD_PRECHARGE) begin
            if (all_banks) begin
                open_d = 8'h00;
            end else begin
                open_d[bank_select_inputs] = 1'b0;
            end
        end
        if (cmd == dram_cmd_pkg::CMD_MRS && mr_sel == 2'h0) begin
            bl_d = row_address_inputs[1:0];
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            open_q <= 8'h00;
            bl_q <= 2'h0;
        end else begin
            open_q <= open_d;
            bl_q <= bl_d;
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    property p_eight;
        rdwr && row_address_inputs[12] && bl_q != 2'h2
            |=> burst_beats_q == 2'h2 || cmd_err;
    endproperty
    a_eight: assert property (p_eight) else $error("no eight beat");
    property p_chop;
        rdwr && !row_address_inputs[12] && bl_q == 2'h1
            |=> burst_beats_q == 2'h1 || cmd_err;
    endproperty
    a_chop: assert property (p_chop) else $error("no chop four");
    property p_cause;
        burst_beats_q != 2'h0 |-> $past(rdwr);
    endproperty
    a_cause: assert property (p_cause) else $error("stray burst");
    property p_busy;
        burst_beats_q != 2'h0 |-> burst_busy [*3] ##[1:2] !burst_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("bad ccd window");
    property p_dup_act;
        cmd == dram_cmd_pkg::CMD_ACTIVE ##1
            cmd == dram_cmd_pkg::CMD_ACTIVE && $stable(bank_select_inputs)
            |=> cmd_err;
    endproperty
    a_dup_act: assert property (p_dup_act) else $error("reopen taken");
    property p_closed;
        rdwr && !open_q[bank_select_inputs] |=> cmd_err;
    endproperty
    a_closed: assert property (p_closed) else $error("closed access");
    property p_mrs;
        !(cmd == dram_cmd_pkg::CMD_MRS && mr_sel == 2'h2 &&
          row_address_inputs[7:6] == 2'h3);
    endproperty
    a_mrs: assert property (p_mrs) else $error("illegal mode sent");
    property p_reopen;
        cmd == dram_cmd_pkg::CMD_PRECHARGE && !all_banks ##1
            cmd == dram_cmd_pkg::CMD_NOP [*2] ##1
            cmd == dram_cmd_pkg::CMD_ACTIVE &&
            bank_select_inputs == $past(bank_select_inputs, 3)
            |=> !cmd_err;
    endproperty
    a_reopen: assert property (p_reopen) else $error("reopen refused");
endmodule

//--- bench/tb_dram_bank_cmd_selfrefresh_opts.sv
// Purpose: bench for both ends joined on one link
// Assumes: register port, read data one cycle after strobe
// Notes: reg0 order, reg1 address word, reg2 status, reg3 zero
`timescale 1ns/1ps
module tb_dram_bank_cmd_selfrefresh_opts;
    logic core_clk;
    logic nrst;
    logic [1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata_q;
    logic [1:0] sr_rate_q;
    logic [14:0] open_row_q;
    logic [7:0] bank_open_q;
    logic [31:0] seen;
    logic [1:0] beats_seen = 2'h0;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    dram_cmd_if link ();
    dram_bank_ctrl i_dram_bank_ctrl (.core_clk(core_clk), .nrst(nrst),
        .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_q(rdata_q));
    dram_bank_dev i_dram_bank_dev (.core_clk(core_clk), .nrst(nrst),
        .link(link), .sr_rate_q(sr_rate_q), .open_row_q(open_row_q),
        .bank_open_q(bank_open_q));
    dram_bank_link_sva i_dram_bank_link_sva (.core_clk(core_clk),
        .nrst(nrst), .cmd(link.cmd),
        .bank_select_inputs(link.bank_select_inputs),
        .row_address_inputs(link.row_address_inputs),
        .all_banks(link.all_banks), .mr_sel(link.mr_sel),
        .cmd_err(link.cmd_err), .burst_beats_q(link.burst_beats_q),
        .burst_busy(link.burst_busy));
    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wreg(input logic [1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge core_clk);
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    task automatic rreg(input logic [1:0] a);
        @(posedge core_clk);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        idle(1);
        #1;
        seen = rdata_q;
    endtask
    task automatic op(input dram_cmd_pkg::cmd_e c, input logic [2:0] b,
                      input logic [1:0] m, input logic [14:0] r);
        wreg(2'h1, {11'h0, b, m, 1'b0, r});
        wreg(2'h0, {29'h0, c});
        // outlasts the burst window so the next order is never dropped
        idle(6);
        // look after the edge's updates have landed
        #1;
    endtask
    task automatic err_is(input logic e);
        rreg(2'h2);
        check(seen & 32'h1, {31'h0, e});
        wreg(2'h2, 32'h0);
        idle(1);
    endtask
    always @(posedge core_clk) begin
        if (link.burst_beats_q != 2'h0) begin
            beats_seen <= link.burst_beats_q;
        end else if (wr) begin
            // cleared per order so a missing burst cannot pass as stale
            beats_seen <= 2'h0;
        end
    end
    // ==========================================
    // scenarios
    task automatic t_mode;
        logic [14:0] rows [4] = '{15'h0000, 15'h0080, 15'h0040, 15'h00C0};
        logic [1:0] exps [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
        foreach (rows[i]) begin
            op(dram_cmd_pkg::CMD_MRS, 3'h0, 2'h2, rows[i]);
            check({30'h0, sr_rate_q}, {30'h0, exps[i]});
        end
        $display("test mode done");
    endtask
    task automatic t_act;
        op(dram_cmd_pkg::CMD_ACTIVE, 3'h3, 2'h0, 15'h5A5A);
        check({24'h0, bank_open_q}, 32'h8);
        err_is(1'b0);
        op(dram_cmd_pkg::CMD_ACTIVE, 3'h3, 2'h0, 15'h1111);
        err_is(1'b1);
        check({17'h0, open_row_q}, 32'h5A5A);
        wreg(2'h0, {29'h0, dram_cmd_pkg::CMD_ACTIVE});
        wreg(2'h0, {29'h0, dram_cmd_pkg::CMD_ACTIVE});
        idle(6);
        err_is(1'b1);
        $display("test activate done");
    endtask
    task automatic t_burst;
        op(dram_cmd_pkg::CMD_MRS, 3'h0, 2'h0, 15'h0001);
        for (int i = 0; i < 4; i++) begin
            op(i[0] ? dram_cmd_pkg::CMD_WRITE : dram_cmd_pkg::CMD_READ,
               3'h3, 2'h0, {2'h0, i[1], 12'h020});
            check({30'h0, beats_seen}, i[1] ? 32'h2 : 32'h1);
        end
        op(dram_cmd_pkg::CMD_MRS, 3'h0, 2'h0, 15'h0002);
        op(dram_cmd_pkg::CMD_READ, 3'h3, 2'h0, 15'h1020);
        check({30'h0, beats_seen}, 32'h1);
        err_is(1'b0);
        $display("test burst done");
    endtask
    task automatic t_prech;
        op(dram_cmd_pkg::CMD_PRECHARGE, 3'h3, 2'h0, 15'h0000);
        check({24'h0, bank_open_q}, 32'h0);
        op(dram_cmd_pkg::CMD_READ, 3'h3, 2'h0, 15'h0000);
        err_is(1'b1);
        wreg(2'h1, 32'h000C0000);
        wreg(2'h0, {29'h0, dram_cmd_pkg::CMD_PRECHARGE});
        idle(1);
        wreg(2'h1, 32'h000C0000);
        wreg(2'h0, {29'h0, dram_cmd_pkg::CMD_ACTIVE});
        idle(6);
        err_is(1'b0);
        op(dram_cmd_pkg::CMD_ACTIVE, 3'h5, 2'h0, 15'h0001);
        check({24'h0, bank_open_q}, 32'h28);
        op(dram_cmd_pkg::CMD_PRECHARGE, 3'h0, 2'h0, 15'h0400);
        check({24'h0, bank_open_q}, 32'h0);
        $display("test precharge done");
    endtask
    // ==========================================
    // clock, run and watchdog
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        nrst = 1'b0;
        addr = 2'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        rreg(2'h3);
        check(seen, 32'h0);
        t_mode;
        t_act;
        t_burst;
        t_prech;
        summarize;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1500) begin
            fail_count++;
            summarize;
        end
    end
endmodule
